// file: mrr_pkg.sv
// Constants and encodings for the mode register read path
// How it works
// - MRR, MRW accepted during self-refresh exit
// - MRR, MRW accepted during refresh cycles
// - Six-bit address picks one of 64 registers
// - Register bits on DQ0-7 for first 4 UI
// - Remaining burst bits driven as zero
// - Strobe toggles for whole read burst
// - Mode register read burst is 16 UI unless the next queued read launches first
// - Same preamble and postamble as normal read
// - MRW to read-only register changes nothing
package mrr_pkg;
   localparam int       CA_W       = 6;
   localparam int       MA_W       = 6;
   localparam int       MR_DEPTH   = 64;
   localparam int       DAT_W      = 8;
   localparam int       DQ_W       = 16;
   localparam int       DMI_W      = 2;
   localparam int       UI_W       = 16;
   localparam int       FIFO_DEPTH = 8;
   localparam int       BURST_LEN  = 16;
   localparam int       OUT_UI     = 4;
   localparam int       PRE_UI     = 4;
   localparam int       POST_UI    = 1;
   localparam int       READ_LAT   = 14;
   localparam int       TMRR_NCK   = 8;
   localparam int       MRW_MIN_NS = 10;
   localparam int       MRD_MIN_NS = 14;
   localparam int       CLK_NS     = 10;
   localparam int       MRW_CYC    = (MRW_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int       MRD_CYC    = (MRD_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [4:0] CODE_MRR1 = 5'h0e;
   localparam logic [4:0] CODE_MRW1 = 5'h06;
   localparam logic [4:0] CODE_MRW2 = 5'h16;
   localparam logic [MA_W-1:0] RO_FIRST = 6'h05;
   localparam logic [MA_W-1:0] RO_LAST  = 6'h08;
   localparam logic [DAT_W-1:0] MR_RESET = 8'h00;
   localparam logic [UI_W-1:0] LAUNCH_UI = 16'h001c;
   localparam logic [UI_W-1:0] PRE_SPAN  = 16'h0004;
   localparam logic [4:0] BURST_LAST = 5'h0f;
   localparam logic [4:0] OUT_LAST   = 5'h03;
   localparam logic [4:0] PRE_LAST   = 5'h03;

   typedef enum logic [2:0]
   {
      CMD_IDLE = 3'b001,
      CMD_MRR  = 3'b010,
      CMD_MRW  = 3'b100
   } mrr_cmd_e;

   typedef enum logic [3:0]
   {
      SER_IDLE = 4'b0001,
      SER_PRE  = 4'b0010,
      SER_DATA = 4'b0100,
      SER_POST = 4'b1000
   } mrr_ser_e;
endpackage : mrr_pkg

// file: mrr_readout.sv
// Mode register file, command capture and read burst serializer
`timescale 1ns/1ns
`default_nettype none

module mrr_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      cnt_ff;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem[rd_ff];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ff] <= in_data;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (push)
            wr_ff <= wr_ff + 1'b1;
         if (pop)
            rd_ff <= rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : mrr_fifo

module mrr_readout
   import mrr_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ck,
   input  wire logic                     cs,
   input  wire logic [mrr_pkg::CA_W-1:0] ca,
   output logic      [mrr_pkg::DQ_W-1:0] dq_o,
   output logic                          dq_oe_n,
   output logic      [mrr_pkg::DMI_W-1:0] dmi_o,
   output logic                          dqs_t_o,
   output logic                          dqs_c_o,
   output logic                          dqs_oe_n,
   output logic                          mrr_drop
);
   // Pin synchronisers: stage one feeds only stage two
   logic [CA_W+1:0] s1_ff;
   logic [CA_W+1:0] s2_ff;
   logic            ck_d_ff;
   wire             ck_s  = s2_ff[CA_W+1];
   wire             cs_s  = s2_ff[CA_W];
   wire [CA_W-1:0]  ca_s  = s2_ff[CA_W-1:0];
   wire             rise  = ck_s && !ck_d_ff;
   wire             ui_tk = ck_s != ck_d_ff;

   // Command capture
   mrr_cmd_e        cmd_ff;
   logic [1:0]      ph_ff;
   logic [MA_W-1:0] wa_ff;
   logic [DAT_W-1:0] wd_ff;
   logic [UI_W-1:0] ui_ff;
   logic [DAT_W-1:0] mr_mem [MR_DEPTH];
   logic            drop_ff;

   wire first  = rise && cs_s;
   wire is_mrr1 = first && ca_s[4:0] == CODE_MRR1 && cmd_ff == CMD_IDLE;
   wire is_mrw1 = first && ca_s[4:0] == CODE_MRW1 && cmd_ff == CMD_IDLE;
   wire is_mrw2 = first && ca_s[4:0] == CODE_MRW2 && cmd_ff == CMD_MRW
                  && ph_ff == 2'd1;
   wire second = rise && !cs_s;
   wire mrr_go = second && cmd_ff == CMD_MRR;
   wire mrw_go = second && cmd_ff == CMD_MRW && ph_ff == 2'd2;
   wire ro_hit = (wa_ff >= RO_FIRST) && (wa_ff <= RO_LAST);
   wire [DAT_W-1:0] rd_val = mr_mem[ca_s];

   // Queue entry: launch UI index and register contents
   localparam int QW = UI_W + DAT_W;
   wire          q_in_rdy;
   wire          q_out_vld;
   wire [QW-1:0] q_out;
   logic         q_pop;
   wire [UI_W-1:0]  launch = ui_ff + LAUNCH_UI;
   wire [UI_W-1:0]  h_launch = q_out[QW-1:DAT_W];
   wire [DAT_W-1:0] h_data   = q_out[DAT_W-1:0];

   mrr_fifo #(.WIDTH(QW), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (mrr_go),
      .in_ready  (q_in_rdy),
      .in_data   ({launch, rd_val}),
      .out_valid (q_out_vld),
      .out_ready (q_pop),
      .out_data  (q_out)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_ff   <= '0;
         s2_ff   <= '0;
         ck_d_ff <= 1'b0;
         ui_ff   <= '0;
      end
      else
      begin
         s1_ff   <= {ck, cs, ca};
         s2_ff   <= s1_ff;
         ck_d_ff <= ck_s;
         if (ui_tk)
            ui_ff <= ui_ff + 1'b1;
      end
   end

   // No refresh or self-refresh gating on these commands
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmd_ff  <= CMD_IDLE;
         ph_ff   <= '0;
         wa_ff   <= '0;
         wd_ff   <= '0;
         drop_ff <= 1'b0;
      end
      else
      begin
         case (cmd_ff)
            CMD_IDLE:
            begin
               if (is_mrr1)
                  cmd_ff <= CMD_MRR;
               else if (is_mrw1)
               begin
                  cmd_ff   <= CMD_MRW;
                  ph_ff    <= 2'd0;
                  wd_ff[7] <= ca_s[5];
               end
            end
            CMD_MRR:
            begin
               if (second)
                  cmd_ff <= CMD_IDLE;
            end
            CMD_MRW:
            begin
               if (second && ph_ff == 2'd0)
               begin
                  wa_ff <= ca_s;
                  ph_ff <= 2'd1;
               end
               else if (is_mrw2)
               begin
                  wd_ff[6] <= ca_s[5];
                  ph_ff    <= 2'd2;
               end
               else if (mrw_go)
                  cmd_ff <= CMD_IDLE;
            end
            default:
               cmd_ff <= CMD_IDLE;
         endcase
         // Queue full means the controller broke its spacing; flag it
         if (mrr_go && !q_in_rdy)
            drop_ff <= 1'b1;
      end
   end

   // Read-only registers ignore writes; contents reset to zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < MR_DEPTH; i++)
            mr_mem[i] <= MR_RESET;
      end
      else if (mrw_go && !ro_hit)
         mr_mem[wa_ff] <= {wd_ff[7:6], ca_s};
   end

   // Serializer runs on link UI ticks
   mrr_ser_e        ser_ff;
   logic [4:0]      cnt_ff;
   logic [DAT_W-1:0] dat_ff;
   logic            dqs_ff;
   logic            drv_ff;
   logic            sdrv_ff;
   wire             pre_now = q_out_vld && (ui_ff == h_launch - PRE_SPAN);
   wire             dat_now = q_out_vld && (ui_ff == h_launch);

   assign q_pop = ui_tk && dat_now &&
                  (ser_ff == SER_PRE || ser_ff == SER_DATA ||
                   ser_ff == SER_IDLE || ser_ff == SER_POST);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ser_ff  <= SER_IDLE;
         cnt_ff  <= '0;
         dat_ff  <= '0;
         dqs_ff  <= 1'b0;
         drv_ff  <= 1'b0;
         sdrv_ff <= 1'b0;
      end
      else if (ui_tk)
      begin
         if (q_pop)
         begin
            ser_ff  <= SER_DATA;
            cnt_ff  <= '0;
            dat_ff  <= h_data;
            drv_ff  <= 1'b1;
            sdrv_ff <= 1'b1;
            dqs_ff  <= (ser_ff == SER_IDLE) ? 1'b0 : ~dqs_ff;
         end
         else
         begin
            case (ser_ff)
               SER_IDLE:
               begin
                  if (pre_now)
                  begin
                     ser_ff  <= SER_PRE;
                     cnt_ff  <= '0;
                     sdrv_ff <= 1'b1;
                     dqs_ff  <= 1'b0;
                  end
               end
               SER_PRE:
               begin
                  cnt_ff <= cnt_ff + 1'b1;
                  dqs_ff <= ~dqs_ff;
               end
               SER_DATA:
               begin
                  cnt_ff <= cnt_ff + 1'b1;
                  dqs_ff <= ~dqs_ff;
                  if (cnt_ff == OUT_LAST)
                     dat_ff <= '0;
                  if (cnt_ff == BURST_LAST)
                  begin
                     ser_ff <= SER_POST;
                     drv_ff <= 1'b0;
                     dqs_ff <= 1'b0;
                  end
               end
               SER_POST:
               begin
                  ser_ff  <= pre_now ? SER_PRE : SER_IDLE;
                  cnt_ff  <= '0;
                  sdrv_ff <= pre_now;
               end
               default:
                  ser_ff <= SER_IDLE;
            endcase
         end
      end
   end

   // Each of DQ0-7 carries one register bit for four UI; upper lanes stay zero
   assign dq_o     = {{(DQ_W-DAT_W){1'b0}}, dat_ff};
   assign dmi_o    = '0;
   assign dq_oe_n  = ~drv_ff;
   assign dqs_t_o  = dqs_ff;
   assign dqs_c_o  = ~dqs_ff;
   assign dqs_oe_n = ~sdrv_ff;
   assign mrr_drop = drop_ff;
endmodule : mrr_readout

`default_nettype wire

// file: mrr_readout_props.sv
// Assertions on the mode register read output timing
`timescale 1ns/1ns
`default_nettype none
module mrr_readout_chk
   import mrr_pkg::*;
(
   input wire logic                      clk,
   input wire logic                      rst,
   input wire logic [mrr_pkg::DQ_W-1:0]  dq_o,
   input wire logic                      dq_oe_n,
   input wire logic [mrr_pkg::DMI_W-1:0] dmi_o,
   input wire logic                      dqs_t_o,
   input wire logic                      dqs_c_o,
   input wire logic                      dqs_oe_n
);
   logic [15:0] run_ff;
   logic [15:0] nxt_run;
   logic [2:0]  same_ff;
   logic [2:0]  nxt_same;
   logic        last_ff;
   logic [5:0]  pos;
   // Cycles spent driving DQ, and cycles since the strobe last moved
   assign nxt_run  = dq_oe_n ? 16'h0000 : run_ff + 16'h0001;
   assign nxt_same = (dqs_t_o == last_ff) ? same_ff + 3'h1 : 3'h0;
   assign pos      = run_ff[5:0];
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         run_ff  <= 16'h0000;
         same_ff <= 3'h0;
         last_ff <= 1'b0;
      end
      else
      begin
         run_ff  <= nxt_run;
         same_ff <= nxt_same;
         last_ff <= dqs_t_o;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_STROBE_PAIR:
      assert property (dqs_c_o != dqs_t_o)
      else $error("strobe halves not complementary");
   AST_PREAMBLE:
      assert property ($fell(dq_oe_n) |->
         !$past(dqs_oe_n, 16) && $past(dqs_oe_n, 17))
      else $error("preamble not four UI");
   AST_POSTAMBLE:
      assert property ($rose(dq_oe_n) |->
         (!dqs_oe_n && !dqs_t_o) [*4] ##1 dqs_oe_n)
      else $error("postamble not one UI low");
   AST_BURST_LEN:
      assert property ($rose(dq_oe_n) |-> pos == 6'h00 && run_ff != 16'h0000)
      else $error("burst not sixteen UI");
   AST_UPPER_ZERO:
      assert property (dq_o[15:8] == 8'h00 && dmi_o == 2'h0)
      else $error("upper lanes not zero");
   AST_FIRST_UI:
      assert property (!dq_oe_n && pos != 6'h00 && pos < 6'h10 |->
         $stable(dq_o[7:0]))
      else $error("register byte moved early");
   AST_LATER_UI:
      assert property (!dq_oe_n && pos >= 6'h10 |-> dq_o[7:0] == 8'h00)
      else $error("late UI not zero");
   AST_STROBE_RUN:
      assert property (!dq_oe_n |-> !dqs_oe_n && same_ff < 3'h4)
      else $error("strobe idle during burst");
endmodule : mrr_readout_chk
bind mrr_readout mrr_readout_chk chk (.clk, .rst, .dq_o, .dq_oe_n, .dmi_o,
   .dqs_t_o, .dqs_c_o, .dqs_oe_n);
`default_nettype wire

// file: mrr_ctl_model.sv
// Behavioural memory controller driving the command link
`timescale 1ns/1ns
`default_nettype none
module mrr_ctl_model
(
   input  wire logic                     clk,
   output var  logic                     ck,
   output var  logic                     cs,
   output var  logic [mrr_pkg::CA_W-1:0] ca
);
   import mrr_pkg::*;
   initial
   begin
      ck = 1'b0;
      cs = 1'b0;
      ca = 6'h15;
   end
   // One link cycle of 80 ns; the clock stands still only while no task is running
   task automatic cyc(input logic c, input logic [5:0] a);
      @(posedge clk);
      cs <= c;
      ca <= a;
      repeat (3) @(posedge clk);
      ck <= 1'b1;
      repeat (4) @(posedge clk);
      ck <= 1'b0;
   endtask : cyc
   // Idle cycles flip the address pins so nothing stale is read
   task automatic des(input int n);
      repeat (n) cyc(1'b0, ~ca);
   endtask : des
   // Only deselects follow; the burst stays whole only when n is at least 6
   task automatic mrr(input logic [5:0] m, input int n);
      cyc(1'b1, {1'b0, CODE_MRR1});
      cyc(1'b0, m);
      des(n);
   endtask : mrr
   task automatic mrw(input logic [5:0] m, input logic [7:0] op);
      int g;
      cyc(1'b1, {op[7], CODE_MRW1});
      cyc(1'b0, m);
      cyc(1'b1, {op[6], CODE_MRW2});
      cyc(1'b0, op[5:0]);
      g = (MRD_MIN_NS + 79) / 80;
      des(g > 10 ? g : 10);
   endtask : mrw
   // No refresh, data or power-down traffic is sent,
   // so those windows and gaps hold trivially
endmodule : mrr_ctl_model
`default_nettype wire

// file: tb_mrr_readout.sv
// Self-checking bench for the mode register read block
`timescale 1ns/1ns
`default_nettype none
module tb_mrr_readout;
   import mrr_pkg::*;
   logic                      clk;
   logic                      rst;
   logic                      ck;
   logic                      cs;
   logic [mrr_pkg::CA_W-1:0]  ca;
   logic [mrr_pkg::DQ_W-1:0]  dq_o;
   logic                      dq_oe_n;
   logic [mrr_pkg::DMI_W-1:0] dmi_o;
   logic                      dqs_t_o;
   logic                      dqs_c_o;
   logic                      dqs_oe_n;
   logic                      mrr_drop;
   logic [7:0]                got[$];
   int                        run;
   int                        bad_count;
   int                        tests_run;
   mrr_ctl_model ctl (.clk, .ck, .cs, .ca);
   mrr_readout uut (.clk, .rst, .ck, .cs, .ca, .dq_o, .dq_oe_n, .dmi_o,
      .dqs_t_o, .dqs_c_o, .dqs_oe_n, .mrr_drop);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Take the byte on the first clock of the third UI of each burst
   always @(posedge clk)
   begin
      if (dq_oe_n === 1'b0)
      begin
         if (run % 64 == 8)
            got.push_back(dq_o[7:0]);
         run = run + 1;
      end
      else
         run = 0;
   end
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic [7:0] mv(input logic [5:0] m);
      if (m >= RO_FIRST && m <= RO_LAST)
         return 8'h00;
      return {m[1:0], m};
   endfunction : mv
   task automatic rd(input logic [5:0] m, input logic [7:0] e);
      got.delete();
      ctl.mrr(m, 24);
      chk("register byte", e, got.size() == 1 ? got[0] : 8'hxx);
   endtask : rd
   task automatic t_regs;
      logic [5:0] m;
      for (int a = 0; a < 64; a++)
      begin
         m = 6'(a);
         ctl.mrw(m, {m[1:0], m});
      end
      for (int a = 0; a < 64; a++)
         rd(6'(a), mv(6'(a)));
      $display("test registers done");
   endtask : t_regs
   task automatic t_b2b;
      got.delete();
      ctl.mrr(6'h03, 6);
      ctl.mrr(6'h3c, 24);
      chk("burst count", 8'h02, 8'(got.size()));
      chk("first byte", mv(6'h03), got[0]);
      chk("second byte", mv(6'h3c), got[1]);
      $display("test back to back done");
   endtask : t_b2b
   task automatic t_undef;
      got.delete();
      ctl.cyc(1'b1, 6'h1f);
      ctl.cyc(1'b0, 6'h01);
      ctl.des(24);
      chk("bursts on bad code", 8'h00, 8'(got.size()));
      $display("test bad code done");
   endtask : t_undef
   // Pops keep pace with one MRR per eight link cycles, as in this train, so the queue
   // never fills; a seamless train must not raise the drop flag
   task automatic t_drop;
      chk("drop before", 8'h00, {7'h00, mrr_drop});
      got.delete();
      repeat (16) ctl.mrr(6'h01, 6);
      ctl.des(24);
      chk("train bursts", 8'h10, 8'(got.size()));
      chk("train first byte", mv(6'h01), got[0]);
      chk("train last byte", mv(6'h01), got[15]);
      chk("drop after", 8'h00, {7'h00, mrr_drop});
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      chk("drop cleared", 8'h00, {7'h00, mrr_drop});
      repeat (4) @(posedge clk);
      rd(6'h2a, MR_RESET);
      $display("test burst train and reset done");
   endtask : t_drop
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial
   begin
      rst = 1'b1;
      repeat (8) @(posedge clk);
      chk("reset levels", 8'h0e,
         {4'h0, dq_oe_n, dqs_oe_n, dqs_c_o, mrr_drop});
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_regs();
      t_b2b();
      t_undef();
      t_drop();
      summarize();
   end
   // The run needs about 22400 clocks; allow well over that
   initial
   begin
      #400000;
      bad_count++;
      summarize();
   end
endmodule : tb_mrr_readout
`default_nettype wire
